/* File: design/cuetu_map.svh */
`ifndef CUETU_MAP_SVH
`define CUETU_MAP_SVH
// register offsets on the 4-bit register port
`define CUETU_OFF_CLK_CFG 4'h1
`define CUETU_OFF_DIVIDER 4'h2
`define CUETU_OFF_CFG_TWO 4'h3
`define CUETU_OFF_CFG_ONE 4'h6
`define CUETU_OFF_TX_DATA 4'h7
`define CUETU_OFF_RX_DATA 4'h8
`define CUETU_OFF_MAIN_STATUS 4'h9
`define CUETU_OFF_IRQ_STATUS 4'hA
`define CUETU_OFF_IRQ_MASK 4'hB
// field positions in the second configuration register
`define CUETU_C2_PSC 0
`define CUETU_C2_HALF 1
`define CUETU_C2_CONVSEL 2
`define CUETU_C2_SYNC 3
`define CUETU_C2_RXWAKE 4
`define CUETU_C2_BUFDIS 6
`define CUETU_C2_EXTWAKE 7
`define CUETU_C2_USED 8'hDF
// first configuration register and clock configuration fields
`define CUETU_C1_CONVENTION_BIT 0
`define CUETU_C1_SESSION 1
`define CUETU_CC_LEVEL 3
// interrupt status bit positions
`define CUETU_IRQ_BUF 0
`define CUETU_IRQ_WAKE 1
`define CUETU_IRQ_CONVENTION_BIT 2
`define CUETU_IRQ_SESS 3
// reset values
`define CUETU_RST_BYTE 8'h00
`define CUETU_RST_IRQ 4'h0
// prescaler last counts: 32 and 31 unit ticks per step
`define CUETU_PSC_LAST_32 5'h1F
`define CUETU_PSC_LAST_31 5'h1E
// session end after 10.5 units, expressed as 21 half units
`define CUETU_SESS_HALVES 20'h00015
`define CUETU_DIV_LAST 8'h01
`endif

/* File: design/cuetu_pkg.sv */
package cuetu_pkg;
  // processor side register request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cuetu_bus_req_t;
  // session-start watcher states
  typedef enum logic [2:0] {
    CUETU_SS_IDLE = 3'b001,
    CUETU_SS_WAIT = 3'b010,
    CUETU_SS_COUNT = 3'b100
  } cuetu_sess_t;
endpackage

/* File: design/cuetu_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cuetu_map.svh"

// Notes on behaviour
// - eight-bit divider loads value, counts down to one on unit steps, reloads itself.
// - prescaler select one gives 32 unit ticks per step, zero gives 31.
// - without half option, one time unit is prescaler times divider card clocks.
// - half option counts twice per card clock, halving the time unit.
// - half option ignored when card clock equals the crystal clock.
// - external interrupt falling edge wakes device in power-down when enabled.
// - host receive falling edge wakes device in power-down when enabled.
// - wake enables do nothing outside power-down mode.
// - buffer interrupt disable blocks the interrupt; buffer flag still updates.
// - synchronous card mode bypasses UART; data bit zero drives card I/O.
// - synchronous card mode drives card clock from the clock level bit.
// - convention select one takes convention from the software-written bit.
// - convention select zero detects convention from first character in session.
// - convention bit one means direct, zero inverse; hardware writes after detection.
// - session-start bit clears 10.5 time units after initial character.
module cuetu_top (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // register port
  input wire cuetu_pkg::cuetu_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // card clock timing from the clock generator
  input wire logic card_tick_i,
  input wire logic card_half_tick_i,
  input wire logic card_clk_gen_i,
  input wire logic clk_is_xtal_i,
  // card contacts
  input wire logic card_io_i,
  output logic card_io_out_o,
  output logic card_io_oe_o,
  output logic card_clk_o,
  // UART core side
  input wire logic uart_io_out_i,
  input wire logic uart_io_oe_i,
  input wire logic buffer_flag_i,
  input wire logic init_char_i,
  input wire logic convention_bit_direct_i,
  output logic etu_tick_o,
  output logic convention_bit_o,
  output logic session_o,
  output logic buffer_irq_o,
  // power-down wake
  input wire logic power_down_i,
  input wire logic ext_irq_input_n_i,
  input wire logic host_rx_i,
  output logic wake_o,
  // interrupt
  output logic irq_o
);
  import cuetu_pkg::*;

  logic [7:0] divider_value;
  logic [7:0] cfg_two;
  logic [7:0] cfg_one;
  logic [7:0] clk_cfg;
  logic tx_bit;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [4:0] psc_cnt;
  logic [7:0] div_cnt;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic ext_prev;
  logic rx_prev;
  logic buf_prev;
  logic [19:0] sess_cnt;
  cuetu_sess_t sess_state;
  cuetu_sess_t next_sess_state;
  logic half_on;
  logic unit_tick;
  logic [4:0] psc_last;
  logic psc_wrap;
  logic etu_done;
  logic [14:0] etu_len;
  logic [19:0] sess_target;
  logic sess_end;
  logic convention_bit_det;
  logic ext_fall;
  logic rx_fall;
  logic wake_cond;
  logic [3:0] irq_event;
  logic sync_mode;
  logic io_sync;

  // write strobe decode, used by every register process
  function automatic logic wr_hit(input cuetu_bus_req_t req, input logic [3:0] off);
    wr_hit = req.wr && (req.addr == off);
  endfunction
  assign sync_mode = cfg_two[`CUETU_C2_SYNC];
  assign io_sync = sync_b[0];
  // pin synchronisers: card I/O, external interrupt, host receive
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          sync_a[gi] <= 1'b1;
          sync_b[gi] <= 1'b1;
        end else begin
          sync_a[gi] <= (gi == 0) ? card_io_i : ((gi == 1) ? ext_irq_input_n_i : host_rx_i);
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  // software registers; reserved bit 5 of the second config stays zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      divider_value <= `CUETU_RST_BYTE;
      cfg_two <= `CUETU_RST_BYTE;
      clk_cfg <= `CUETU_RST_BYTE;
      tx_bit <= 1'b1;
      irq_mask <= `CUETU_RST_IRQ;
    end else begin
      if (wr_hit(bus_i, `CUETU_OFF_DIVIDER)) begin
        divider_value <= bus_i.wdata;
      end
      if (wr_hit(bus_i, `CUETU_OFF_CFG_TWO)) begin
        cfg_two <= bus_i.wdata & `CUETU_C2_USED;
      end
      if (wr_hit(bus_i, `CUETU_OFF_CLK_CFG)) begin
        clk_cfg <= bus_i.wdata;
      end
      if (wr_hit(bus_i, `CUETU_OFF_TX_DATA)) begin
        tx_bit <= bus_i.wdata[0];
      end
      if (wr_hit(bus_i, `CUETU_OFF_IRQ_MASK)) begin
        irq_mask <= bus_i.wdata[3:0];
      end
    end
  end

  // unit tick: twice per card clock when the half option applies
  assign half_on = cfg_two[`CUETU_C2_HALF] && !clk_is_xtal_i;
  assign unit_tick = half_on ? card_half_tick_i : card_tick_i;
  assign psc_last = cfg_two[`CUETU_C2_PSC] ? `CUETU_PSC_LAST_32 : `CUETU_PSC_LAST_31;
  assign psc_wrap = unit_tick && (psc_cnt == psc_last);
  // divider value zero wraps through 255, giving 256 steps
  assign etu_done = psc_wrap && (div_cnt == `CUETU_DIV_LAST);

  // prescaler; a divider write restarts the chain so the new rate starts clean
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      psc_cnt <= 5'h00;
    end else if (wr_hit(bus_i, `CUETU_OFF_DIVIDER) || psc_wrap) begin
      psc_cnt <= 5'h00;
    end else if (unit_tick) begin
      psc_cnt <= psc_cnt + 5'h01;
    end
  end

  // auto-reload down-counter
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= `CUETU_RST_BYTE;
    end else if (wr_hit(bus_i, `CUETU_OFF_DIVIDER)) begin
      div_cnt <= bus_i.wdata;
    end else if (etu_done) begin
      div_cnt <= divider_value;
    end else if (psc_wrap) begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  // time unit tick for the UART bit timing
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      etu_tick_o <= 1'b0;
    end else begin
      etu_tick_o <= etu_done && !sync_mode;
    end
  end

  // session-start watcher: counts 21 half units in unit ticks
  assign etu_len = (15'(psc_last) + 15'h0001) * 15'({divider_value == 8'h00, divider_value});
  assign sess_target = 20'(((20'(etu_len) * `CUETU_SESS_HALVES) >> 1) - 20'h00001);
  assign sess_end = (sess_state == CUETU_SS_COUNT) && unit_tick && (sess_cnt >= sess_target);

  always_comb begin
    next_sess_state = sess_state;
    case (sess_state)
      CUETU_SS_IDLE: begin
        if (cfg_one[`CUETU_C1_SESSION]) begin
          next_sess_state = CUETU_SS_WAIT;
        end
      end
      CUETU_SS_WAIT: begin
        if (!cfg_one[`CUETU_C1_SESSION]) begin
          next_sess_state = CUETU_SS_IDLE;
        end else if (init_char_i) begin
          next_sess_state = CUETU_SS_COUNT;
        end
      end
      CUETU_SS_COUNT: begin
        if (sess_end || !cfg_one[`CUETU_C1_SESSION]) begin
          next_sess_state = CUETU_SS_IDLE;
        end
      end
      default: begin
        next_sess_state = CUETU_SS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sess_state <= CUETU_SS_IDLE;
      sess_cnt <= 20'h00000;
    end else begin
      sess_state <= next_sess_state;
      if (sess_state != CUETU_SS_COUNT) begin
        sess_cnt <= 20'h00000;
      end else if (unit_tick) begin
        sess_cnt <= sess_cnt + 20'h00001;
      end
    end
  end

  // first config: software bits, convention and session written by hardware too
  assign convention_bit_det = init_char_i && (sess_state == CUETU_SS_WAIT) && !cfg_two[`CUETU_C2_CONVSEL];
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_one <= `CUETU_RST_BYTE;
    end else begin
      if (wr_hit(bus_i, `CUETU_OFF_CFG_ONE)) begin
        cfg_one <= {bus_i.wdata[7:1],
                    cfg_two[`CUETU_C2_CONVSEL] ? bus_i.wdata[0] : cfg_one[0]};
      end
      if (convention_bit_det) begin
        cfg_one[`CUETU_C1_CONVENTION_BIT] <= convention_bit_direct_i;
      end
      if (sess_end) begin
        cfg_one[`CUETU_C1_SESSION] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      convention_bit_o <= 1'b0;
      session_o <= 1'b0;
    end else begin
      convention_bit_o <= cfg_one[`CUETU_C1_CONVENTION_BIT];
      session_o <= cfg_one[`CUETU_C1_SESSION];
    end
  end

  // card line: synchronous mode bypasses the UART and drives only a low; UART mode passes its drive through
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      card_io_out_o <= 1'b0;
      card_io_oe_o <= 1'b0;
      card_clk_o <= 1'b0;
    end else begin
      card_io_out_o <= sync_mode ? 1'b0 : uart_io_out_i;
      card_io_oe_o <= sync_mode ? !tx_bit : uart_io_oe_i;
      card_clk_o <= sync_mode ? clk_cfg[`CUETU_CC_LEVEL] : card_clk_gen_i;
    end
  end

  // wake edges; prev flops follow the second synchroniser stage only
  assign ext_fall = ext_prev && !sync_b[1] && cfg_two[`CUETU_C2_EXTWAKE];
  assign rx_fall = rx_prev && !sync_b[2] && cfg_two[`CUETU_C2_RXWAKE];
  assign wake_cond = power_down_i && (ext_fall || rx_fall);
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_prev <= 1'b1;
      rx_prev <= 1'b1;
      buf_prev <= 1'b0;
      wake_o <= 1'b0;
      buffer_irq_o <= 1'b0;
    end else begin
      ext_prev <= sync_b[1];
      rx_prev <= sync_b[2];
      buf_prev <= buffer_flag_i;
      wake_o <= wake_cond;
      buffer_irq_o <= buffer_flag_i && !cfg_two[`CUETU_C2_BUFDIS];
    end
  end

  // sticky status: a new event beats a write-one clear in the same cycle
  assign irq_event[`CUETU_IRQ_BUF] = buffer_flag_i && !buf_prev && !cfg_two[`CUETU_C2_BUFDIS];
  assign irq_event[`CUETU_IRQ_WAKE] = wake_cond;
  assign irq_event[`CUETU_IRQ_CONVENTION_BIT] = convention_bit_det;
  assign irq_event[`CUETU_IRQ_SESS] = sess_end;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_status <= `CUETU_RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      if (wr_hit(bus_i, `CUETU_OFF_IRQ_STATUS)) begin
        irq_status <= (irq_status & ~bus_i.wdata[3:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // read data in the cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= `CUETU_RST_BYTE;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        `CUETU_OFF_CLK_CFG: rdata_o <= clk_cfg;
        `CUETU_OFF_DIVIDER: rdata_o <= divider_value;
        `CUETU_OFF_CFG_TWO: rdata_o <= cfg_two;
        `CUETU_OFF_CFG_ONE: rdata_o <= cfg_one;
        `CUETU_OFF_TX_DATA: rdata_o <= {7'h00, tx_bit};
        `CUETU_OFF_RX_DATA: rdata_o <= {7'h00, io_sync};
        `CUETU_OFF_MAIN_STATUS: rdata_o <= {7'h00, buffer_flag_i};
        `CUETU_OFF_IRQ_STATUS: rdata_o <= {4'h0, irq_status};
        `CUETU_OFF_IRQ_MASK: rdata_o <= {4'h0, irq_mask};
        default: rdata_o <= `CUETU_RST_BYTE;
      endcase
    end else begin
      rdata_o <= `CUETU_RST_BYTE;
    end
  end

  // checks
  etu_tick_cause_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    etu_tick_o |-> $past(psc_wrap && div_cnt == 8'h01 && !sync_mode))
    else $error("time unit tick without completed period");
  div_reload_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (etu_done && !bus_i.wr) |=> (div_cnt == $past(divider_value)))
    else $error("divider did not reload");
  div_step_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (psc_wrap && !etu_done && !bus_i.wr) |=> (div_cnt == $past(div_cnt) - 8'h01))
    else $error("divider did not count down");
  psc_range_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (unit_tick && !bus_i.wr && psc_cnt == (cfg_two[0] ? 5'h1F : 5'h1E)) |=> (psc_cnt == 5'h00))
    else $error("prescaler wrapped at wrong count");
  half_unit_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    clk_is_xtal_i |-> (unit_tick == card_tick_i))
    else $error("half option active on crystal clock");
  wake_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wake_o |-> $past(power_down_i))
    else $error("wake outside power-down");
  ext_wake_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (power_down_i && cfg_two[7] && ext_prev && !sync_b[1]) |=> wake_o)
    else $error("external falling edge did not wake");
  buf_irq_block_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    buffer_irq_o |-> !$past(cfg_two[6]))
    else $error("buffer interrupt while disabled");
  sync_io_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(sync_mode) |-> (card_io_oe_o == !$past(tx_bit) && !card_io_out_o))
    else $error("card line not bypassed in sync mode");
  sync_clk_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    $past(sync_mode) |-> (card_clk_o == $past(clk_cfg[3])))
    else $error("card clock not from level bit");
  auto_convention_bit_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    convention_bit_det |=> (cfg_one[0] == $past(convention_bit_direct_i)))
    else $error("convention not detected");
  sess_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    (sess_end && !bus_i.wr) |=> !cfg_one[1] ##1 !session_o)
    else $error("session start not cleared");
endmodule
`default_nettype wire

/* File: verif/cuetu_card_model.sv */
`timescale 1ns/100ps
`default_nettype none
// card side of the I/O contact: open drain with a pull-up, so a released line reads high
module cuetu_card_model (
  // reader drive
  input wire logic io_out_i,
  input wire logic io_oe_i,
  // card pulls the line low while this is high
  input wire logic card_low_i,
  // resolved contact level
  output logic io_line_o
);
  // either party may pull low; nobody driving leaves the pull-up in charge
  assign io_line_o = (card_low_i || (io_oe_i && !io_out_i)) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* File: verif/card_uart_etu_divider_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "cuetu_map.svh"
module card_uart_etu_divider_config_tb;
  import cuetu_pkg::*;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, ph = 1'b0, card_low = 1'b0, unit_half = 1'b0, rd_d = 1'b0;
  cuetu_bus_req_t bus_i = '0;
  logic card_tick_i = 1'b0, card_half_tick_i = 1'b0, card_clk_gen_i = 1'b0, clk_is_xtal_i = 1'b0;
  logic buffer_flag_i = 1'b0, init_char_i = 1'b0, convention_bit_direct_i = 1'b0, power_down_i = 1'b0;
  logic ext_irq_input_n_i = 1'b1, host_rx_i = 1'b1;
  logic uart_io_out_i = 1'b0, uart_io_oe_i = 1'b0;
  wire logic card_io_i;
  logic [7:0] rdata_o;
  logic card_io_out_o, card_io_oe_o, card_clk_o, etu_tick_o, convention_bit_o, session_o;
  logic buffer_irq_o, wake_o, irq_o;
  int mismatches = 0, checked = 0, ucnt = 0, wakes = 0;
  logic [31:0] seed = 32'h0000F6AC, v;
  logic [7:0] rq[$];
  int eq[$];

  cuetu_top uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .card_tick_i(card_tick_i), .card_half_tick_i(card_half_tick_i),
    .card_clk_gen_i(card_clk_gen_i), .clk_is_xtal_i(clk_is_xtal_i), .card_io_i(card_io_i),
    .card_io_out_o(card_io_out_o), .card_io_oe_o(card_io_oe_o), .card_clk_o(card_clk_o),
    .uart_io_out_i(uart_io_out_i), .uart_io_oe_i(uart_io_oe_i), .buffer_flag_i(buffer_flag_i),
    .init_char_i(init_char_i), .convention_bit_direct_i(convention_bit_direct_i), .etu_tick_o(etu_tick_o),
    .convention_bit_o(convention_bit_o), .session_o(session_o), .buffer_irq_o(buffer_irq_o),
    .power_down_i(power_down_i), .ext_irq_input_n_i(ext_irq_input_n_i),
    .host_rx_i(host_rx_i), .wake_o(wake_o), .irq_o(irq_o));
  cuetu_card_model card (.io_out_i(card_io_out_o), .io_oe_i(card_io_oe_o),
    .card_low_i(card_low), .io_line_o(card_io_i));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  // card clock generator: one card tick every other cycle, a half tick every cycle
  always @(posedge mclk_i) begin
    ph <= ~ph;
    card_tick_i <= ph;
    card_half_tick_i <= 1'b1;
    if (ph) card_clk_gen_i <= ~card_clk_gen_i;
    rd_d <= bus_i.rd;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // watcher: read data, time unit periods and wake pulses, all sampled mid-cycle
  always @(negedge mclk_i) begin
    if (rd_d && rq.size() > 0) chk("rdata", rq.pop_front(), rdata_o);
    else if (!rd_d) chk("rdata idle", 8'h00, rdata_o);
    if (etu_tick_o === 1'b1) begin
      if (eq.size() > 0) chk("etu period", eq.pop_front(), ucnt);
      ucnt = 0;
    end
    if (unit_half ? card_half_tick_i : card_tick_i) ucnt++;
    if (wake_o === 1'b1) wakes++;
  end

  // every access starts after a rising edge and releases after the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i) bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i) bus_i <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i) bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i) bus_i <= '0;
    rq.push_back(exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic wait_etu;
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (etu_tick_o !== 1'b1 && n < 20000);
    // let the watcher settle this tick before new notes are queued
    @(posedge mclk_i);
    if (n >= 20000) chk("etu tick seen", 1, 0);
  endtask
  // the first period after a reprogram is discarded, the next two are compared
  task automatic etu_case(input logic prescaler_select, input logic half, input logic xtal,
                          input logic [7:0] d, input int exp);
    @(posedge mclk_i) clk_is_xtal_i <= xtal;
    unit_half = half && !xtal;
    wr(`CUETU_OFF_CFG_TWO, {6'h00, half, prescaler_select});
    wr(`CUETU_OFF_DIVIDER, d);
    wait_etu();
    eq.push_back(exp);
    eq.push_back(exp);
    wait_etu();
    wait_etu();
  endtask

  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // reset values, random divider, reserved bit, unmapped offsets
    rd(`CUETU_OFF_DIVIDER, 8'h00);
    rd(`CUETU_OFF_CFG_TWO, 8'h00);
    v = xs(seed);
    wr(`CUETU_OFF_DIVIDER, v[7:0]);
    rd(`CUETU_OFF_DIVIDER, v[7:0]);
    wr(`CUETU_OFF_CFG_TWO, 8'hFF);
    rd(`CUETU_OFF_CFG_TWO, 8'hDF);
    wr(`CUETU_OFF_CFG_TWO, 8'h00);
    wr(4'hC, v[15:8]);
    rd(4'hC, 8'h00);
    rd(4'h4, 8'h00);
    // buffer event: masked, unmasked, cleared, then disabled
    @(posedge mclk_i) buffer_flag_i <= 1'b1;
    cyc(3);
    chk("buffer irq", 1, buffer_irq_o);
    chk("irq masked", 0, irq_o);
    wr(`CUETU_OFF_IRQ_MASK, 8'h01);
    cyc(2);
    chk("irq", 1, irq_o);
    rd(`CUETU_OFF_IRQ_STATUS, 8'h01);
    @(posedge mclk_i) buffer_flag_i <= 1'b0;
    wr(`CUETU_OFF_IRQ_STATUS, 8'h01);
    cyc(2);
    chk("irq cleared", 0, irq_o);
    wr(`CUETU_OFF_CFG_TWO, 8'h40);
    @(posedge mclk_i) buffer_flag_i <= 1'b1;
    cyc(3);
    chk("buffer irq off", 0, buffer_irq_o);
    chk("irq off", 0, irq_o);
    rd(`CUETU_OFF_MAIN_STATUS, 8'h01);
    rd(`CUETU_OFF_IRQ_STATUS, 8'h00);
    @(posedge mclk_i) buffer_flag_i <= 1'b0;
    // time unit periods counted in unit ticks
    etu_case(1'b0, 1'b0, 1'b0, 8'h02, 62);
    etu_case(1'b1, 1'b0, 1'b0, 8'h01, 32);
    etu_case(1'b1, 1'b1, 1'b0, 8'h03, 96);
    etu_case(1'b0, 1'b1, 1'b1, 8'h01, 31);
    etu_case(1'b1, 1'b1, 1'b0, 8'h00, 8192);
    @(posedge mclk_i) clk_is_xtal_i <= 1'b0;
    unit_half = 1'b0;
    // wake enables, inside and outside power-down
    wr(`CUETU_OFF_CFG_TWO, 8'h90);
    @(posedge mclk_i) ext_irq_input_n_i <= 1'b0;
    cyc(8);
    chk("wake count", 0, wakes);
    @(posedge mclk_i) begin
      ext_irq_input_n_i <= 1'b1;
      power_down_i <= 1'b1;
    end
    cyc(8);
    @(posedge mclk_i) ext_irq_input_n_i <= 1'b0;
    cyc(8);
    chk("wake count", 1, wakes);
    @(posedge mclk_i) host_rx_i <= 1'b0;
    cyc(8);
    chk("wake count", 2, wakes);
    wr(`CUETU_OFF_CFG_TWO, 8'h00);
    @(posedge mclk_i) host_rx_i <= 1'b1;
    cyc(8);
    @(posedge mclk_i) host_rx_i <= 1'b0;
    cyc(8);
    chk("wake count", 2, wakes);
    @(posedge mclk_i) power_down_i <= 1'b0;
    wr(`CUETU_OFF_IRQ_STATUS, 8'hFF);
    // synchronous card: bit zero straight onto the contact, clock from the level bit
    // the UART asks to drive; the bypass must ignore it
    @(posedge mclk_i) begin
      uart_io_oe_i <= 1'b1;
      uart_io_out_i <= 1'b1;
    end
    wr(`CUETU_OFF_CFG_TWO, 8'h08);
    wr(`CUETU_OFF_TX_DATA, 8'h00);
    cyc(2);
    chk("io oe", 1, card_io_oe_o);
    chk("io out", 0, card_io_out_o);
    cyc(4);
    rd(`CUETU_OFF_RX_DATA, 8'h00);
    wr(`CUETU_OFF_TX_DATA, 8'h01);
    cyc(6);
    chk("io oe", 0, card_io_oe_o);
    rd(`CUETU_OFF_RX_DATA, 8'h01);
    @(posedge mclk_i) card_low <= 1'b1;
    cyc(6);
    rd(`CUETU_OFF_RX_DATA, 8'h00);
    @(posedge mclk_i) card_low <= 1'b0;
    wr(`CUETU_OFF_CLK_CFG, 8'h08);
    cyc(2);
    chk("card clock", 1, card_clk_o);
    wr(`CUETU_OFF_CLK_CFG, 8'h00);
    cyc(2);
    chk("card clock", 0, card_clk_o);
    // automatic convention and session end; select stays put for the session
    wr(`CUETU_OFF_CFG_TWO, 8'h00);
    cyc(2);
    chk("io oe uart", 1, card_io_oe_o);
    chk("io out uart", 1, card_io_out_o);
    wr(`CUETU_OFF_DIVIDER, 8'h01);
    wr(`CUETU_OFF_CFG_ONE, 8'h02);
    @(posedge mclk_i) begin
      init_char_i <= 1'b1;
      convention_bit_direct_i <= 1'b1;
    end
    @(posedge mclk_i) init_char_i <= 1'b0;
    cyc(3);
    chk("convention", 1, convention_bit_o);
    cyc(600);
    chk("session", 1, session_o);
    cyc(120);
    chk("session", 0, session_o);
    rd(`CUETU_OFF_IRQ_STATUS, 8'h0C);
    wr(`CUETU_OFF_CFG_ONE, 8'h00);
    rd(`CUETU_OFF_CFG_ONE, 8'h01);
    wr(`CUETU_OFF_CFG_TWO, 8'h04);
    wr(`CUETU_OFF_CFG_ONE, 8'h00);
    cyc(2);
    chk("convention", 0, convention_bit_o);
    // with software convention an initial character must not touch the bit
    wr(`CUETU_OFF_CFG_ONE, 8'h02);
    @(posedge mclk_i) init_char_i <= 1'b1;
    @(posedge mclk_i) init_char_i <= 1'b0;
    cyc(3);
    chk("convention kept", 0, convention_bit_o);
    wr(`CUETU_OFF_CFG_ONE, 8'h00);
    rd(`CUETU_OFF_CFG_ONE, 8'h00);
    cyc(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
